/* File: pfr_pkg.sv */
// Shared constants and code tables for the stream framing block
package pfr_pkg;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned NLP_PERIOD_US = 16;
	localparam int unsigned LINK_LOSS_US  = 50;
	localparam int unsigned NLP_CYC_DEF   = NLP_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned LINK_CYC_DEF  = LINK_LOSS_US * 1000 / CLK_PERIOD_NS;

	// Line symbols, leftmost bit sent first
	localparam logic [4:0] SYM_I = 5'h1f;
	localparam logic [4:0] SYM_J = 5'h18;
	localparam logic [4:0] SYM_K = 5'h11;
	localparam logic [4:0] SYM_T = 5'h0d;
	localparam logic [4:0] SYM_R = 5'h07;

	localparam logic [3:0] PRE_NIB    = 4'h5;
	localparam logic [7:0] PRE_10_PAT = 8'h55;
	localparam logic [2:0] LAST_100   = 3'h4;
	localparam logic [2:0] LAST_10    = 3'h3;
	localparam logic [4:0] IDL_SYMS   = 5'h04;
	localparam logic [7:0] IDL_ONES   = 8'h10;
	localparam logic [7:0] LINK_ONES  = 8'h3c;
	localparam logic [10:0] SCR_SEED  = 11'h7ff;

	typedef enum logic [4:0] {
		PFR_TX_IDLE = 5'b00001,
		PFR_TX_SSD  = 5'b00010,
		PFR_TX_DATA = 5'b00100,
		PFR_TX_ESD  = 5'b01000,
		PFR_TX_IDL  = 5'b10000
	} pfr_tx_e;

	typedef enum logic [2:0] {
		PFR_RX_HUNT = 3'b001,
		PFR_RX_PRE  = 3'b010,
		PFR_RX_DATA = 3'b100
	} pfr_rx_e;

	// Bit order swap: code tables are written first-bit-leftmost, the line sends bit 0 first
	function automatic logic [4:0] pfr_rev5(input logic [4:0] v);
		logic [4:0] r;
		r = '0;
		for (int i = 0; i < 5; i++) begin
			r[i] = v[4 - i];
		end
		return r;
	endfunction

	function automatic logic [4:0] pfr_code(input logic [3:0] n);
		logic [4:0] c;
		case (n)
			4'h0: c = 5'h1e;
			4'h1: c = 5'h09;
			4'h2: c = 5'h14;
			4'h3: c = 5'h15;
			4'h4: c = 5'h0a;
			4'h5: c = 5'h0b;
			4'h6: c = 5'h0e;
			4'h7: c = 5'h0f;
			4'h8: c = 5'h12;
			4'h9: c = 5'h13;
			4'ha: c = 5'h16;
			4'hb: c = 5'h17;
			4'hc: c = 5'h1a;
			4'hd: c = 5'h1b;
			4'he: c = 5'h1c;
			default: c = 5'h1d;
		endcase
		return c;
	endfunction

	// Line-order symbol to nibble; unknown codes give zero
	function automatic logic [3:0] pfr_decode(input logic [4:0] s);
		logic [3:0] n;
		n = '0;
		for (int i = 0; i < 16; i++) begin
			if (pfr_rev5(pfr_code(4'(i))) == s) begin
				n = 4'(i);
			end
		end
		return n;
	endfunction

endpackage

/* File: pfr_scr_if.sv */
// Bit stream link between framing logic and a scrambler instance
`timescale 1ns/1ps
`default_nettype none
interface pfr_scr_if;
	logic din;
	logic dout;
	logic descr;
	modport owner (input din, input descr, output dout);
	modport user  (output din, output descr, input dout);
endinterface
`default_nettype wire

/* File: pfr_scrambler.sv */
// Self-synchronising scrambler / descrambler, one bit per clock
`timescale 1ns/1ps
`default_nettype none
module pfr_scrambler
	import pfr_pkg::*;
(
	input  wire logic    ref_clk,
	input  wire logic    sys_rst,
	pfr_scr_if.owner     scr
);
	logic [10:0] lfsr_ff;
	logic [10:0] nxt_lfsr;

	assign scr.dout = scr.din ^ lfsr_ff[10] ^ lfsr_ff[8];

	// Descrambler history follows the line, scrambler history follows its own output
	always_comb begin
		nxt_lfsr = {lfsr_ff[9:0], scr.descr ? scr.din : scr.dout};
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lfsr_ff <= SCR_SEED;
		end else begin
			lfsr_ff <= nxt_lfsr;
		end
	end

	chk_scr_history: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE_02
		!sys_rst && scr.descr |=> lfsr_ff[0] == $past(scr.din))
		else $error("descrambler history lost");
endmodule
`default_nettype wire

/* File: pfr_stream.sv */
// Framing and nibble/bit stream conversion between MII and twisted pair
// Contract
// (RULE_01) Nibbles taken from the MAC are serialised, encoded and sent on the line.
// (RULE_02) Line bits are decoded and regrouped into nibbles for the MAC.
// (RULE_03) At 100M the first preamble octet is replaced by the start delimiter.
// (RULE_04) At 100M an end delimiter follows the last nibble of each frame.
// (RULE_05) At 100M a received start delimiter is replaced by preamble nibbles.
// (RULE_06) At 100M a received end delimiter stops nibble delivery.
// (RULE_07) At 100M the idle line carries scrambled ones without a break.
// (RULE_08) At 100M the receiver searches for scrambled ones to judge and report link.
// (RULE_09) Frame content passes unchanged and its structure is not examined.
// (RULE_10) At 10M no start delimiter is sent and only an idle delimiter ends a frame.
// (RULE_11) At 10M the receiver locks on the preamble and then delivers preamble nibbles.
// (RULE_12) At 10M link pulses are sent and detected while idle and link is reported.
// (RULE_13) MAC side is MII at 10M or 100M; line side is 10M or 100M, half or full duplex.
// (RULE_14) Configuration and status are exchanged with the management port. No such port here: speed_100 and full_duplex are pins, link_ok is an output.
// (RULE_15) The start delimiter is /J/ then /K/, sent after idle /I/.
// (RULE_16) Nibbles are 4 bits, one per MII transfer, lowest bit sent first.
`timescale 1ns/1ps
`default_nettype none
module pfr_stream
	import pfr_pkg::*;
#(
	parameter int unsigned NLP_CYC  = pfr_pkg::NLP_CYC_DEF,
	parameter int unsigned LINK_CYC = pfr_pkg::LINK_CYC_DEF
) (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       speed_100,
	input  wire logic       full_duplex,
	input  wire logic       mii_tx_en,
	input  wire logic [3:0] mii_txd,
	output logic            mii_tx_take,
	output logic            mii_rx_dv,
	output logic [3:0]      mii_rxd,
	output logic            mii_rx_strobe,
	output logic            mii_crs,
	output logic            mii_col,
	output logic            link_ok,
	output logic            tp_tx,
	input  wire logic       tp_rx
);
	pfr_scr_if tx_scr ();
	pfr_scr_if rx_scr ();

	pfr_scrambler u_tx_scr (.ref_clk(ref_clk), .sys_rst(sys_rst), .scr(tx_scr));
	pfr_scrambler u_rx_scr (.ref_clk(ref_clk), .sys_rst(sys_rst), .scr(rx_scr));

	// Transmit state
	pfr_tx_e     tx_st_ff, nxt_tx_st;
	logic [4:0]  sym_ff, nxt_sym;
	logic [2:0]  bit_cnt_ff, nxt_bit_cnt;
	logic [4:0]  idl_cnt_ff, nxt_idl_cnt;
	logic [23:0] nlp_cnt_ff, nxt_nlp_cnt;
	logic        take_ff, nxt_take;
	logic        tp_tx_ff, nxt_tp_tx;
	logic        tx_last;
	logic        nlp_fire;

	assign tx_last  = bit_cnt_ff == (speed_100 ? LAST_100 : LAST_10);
	assign nlp_fire = !speed_100 && tx_st_ff == PFR_TX_IDLE && nlp_cnt_ff == '0;
	assign tx_scr.din   = sym_ff[0];
	assign tx_scr.descr = 1'b0;

	always_comb begin
		nxt_tx_st   = tx_st_ff;
		nxt_sym     = {1'b0, sym_ff[4:1]}; // see RULE_16
		nxt_bit_cnt = tx_last ? 3'h0 : bit_cnt_ff + 3'h1;
		nxt_idl_cnt = idl_cnt_ff;
		nxt_take    = 1'b0;
		nxt_nlp_cnt = (nlp_cnt_ff == '0) ? 24'(NLP_CYC - 1) : nlp_cnt_ff - 24'h1;
		if (tx_st_ff != PFR_TX_IDLE || speed_100) begin
			nxt_nlp_cnt = 24'(NLP_CYC - 1);
		end
		// Line bit: scrambled at 100M, raw plus link pulses at 10M
		nxt_tp_tx = speed_100 ? tx_scr.dout : (sym_ff[0] | nlp_fire); // see RULE_07, RULE_12
		if (tx_last) begin
			case (tx_st_ff)
				PFR_TX_IDLE: begin
					nxt_sym = speed_100 ? pfr_rev5(SYM_I) : 5'h00; // see RULE_07
					if (mii_tx_en) begin
						nxt_take = 1'b1; // see RULE_01
						if (speed_100) begin
							nxt_sym   = pfr_rev5(SYM_J); // see RULE_03, RULE_15
							nxt_tx_st = PFR_TX_SSD;
						end else begin
							nxt_sym   = {1'b0, mii_txd}; // see RULE_10
							nxt_tx_st = PFR_TX_DATA;
						end
					end
				end
				PFR_TX_SSD: begin
					nxt_sym   = pfr_rev5(SYM_K); // see RULE_03, RULE_15
					nxt_take  = 1'b1;
					nxt_tx_st = PFR_TX_DATA;
				end
				PFR_TX_DATA: begin
					if (mii_tx_en) begin
						nxt_take = 1'b1;
						// Content carried as-is, no field is looked at
						nxt_sym  = speed_100 ? pfr_rev5(pfr_code(mii_txd)) : {1'b0, mii_txd}; // see RULE_09
					end else if (speed_100) begin
						nxt_sym   = pfr_rev5(SYM_T); // see RULE_04
						nxt_tx_st = PFR_TX_ESD;
					end else begin
						nxt_sym     = 5'h1f; // see RULE_10
						nxt_idl_cnt = IDL_SYMS;
						nxt_tx_st   = PFR_TX_IDL;
					end
				end
				PFR_TX_ESD: begin
					nxt_sym   = pfr_rev5(SYM_R); // see RULE_04
					nxt_tx_st = PFR_TX_IDLE;
				end
				PFR_TX_IDL: begin
					nxt_sym     = 5'h1f;
					nxt_idl_cnt = idl_cnt_ff - 5'h1;
					if (idl_cnt_ff == 5'h1) begin
						nxt_tx_st = PFR_TX_IDLE;
					end
				end
				default: begin
					nxt_tx_st = PFR_TX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_st_ff   <= PFR_TX_IDLE;
			sym_ff     <= 5'h00;
			bit_cnt_ff <= 3'h0;
			idl_cnt_ff <= 5'h00;
			nlp_cnt_ff <= 24'h000000;
			take_ff    <= 1'b0;
			tp_tx_ff   <= 1'b0;
		end else begin
			tx_st_ff   <= nxt_tx_st;
			sym_ff     <= nxt_sym;
			bit_cnt_ff <= nxt_bit_cnt;
			idl_cnt_ff <= nxt_idl_cnt;
			nlp_cnt_ff <= nxt_nlp_cnt;
			take_ff    <= nxt_take;
			tp_tx_ff   <= nxt_tp_tx;
		end
	end

	// Receive state
	logic        rx_meta_ff, rx_sync_ff;
	pfr_rx_e     rx_st_ff, nxt_rx_st;
	logic [9:0]  sh_ff, nxt_sh;
	logic [2:0]  rcnt_ff, nxt_rcnt;
	logic [7:0]  ones_ff, nxt_ones;
	logic [23:0] link_cnt_ff, nxt_link_cnt;
	logic        dv_ff, nxt_dv;
	logic [3:0]  rxd_ff, nxt_rxd;
	logic        rstb_ff, nxt_rstb;
	logic        link_ff, nxt_link;
	logic        crs_ff, nxt_crs;
	logic        col_ff, nxt_col;
	logic        rbit;
	logic [9:0]  sh_in;
	logic        ssd_hit, rsym_done, link_hit;

	assign rx_scr.din   = rx_sync_ff;
	assign rx_scr.descr = 1'b1;
	assign rbit      = speed_100 ? rx_scr.dout : rx_sync_ff;
	assign sh_in     = {rbit, sh_ff[9:1]};
	assign ssd_hit   = sh_in[4:0] == pfr_rev5(SYM_J) && sh_in[9:5] == pfr_rev5(SYM_K); // see RULE_15
	assign rsym_done = rcnt_ff == (speed_100 ? LAST_100 : LAST_10);
	// Idle ones at 100M, a lone pulse at 10M
	// At 100M held while idle lasts, so a long idle keeps the link up
	assign link_hit  = speed_100 ? (ones_ff >= LINK_ONES)
		: (rx_st_ff == PFR_RX_HUNT && sh_in[9:7] == 3'b010);

	always_comb begin
		nxt_sh       = sh_in;
		nxt_rx_st    = rx_st_ff;
		nxt_rcnt     = rsym_done ? 3'h0 : rcnt_ff + 3'h1;
		nxt_ones     = rbit ? ((ones_ff == 8'hff) ? ones_ff : ones_ff + 8'h1) : 8'h00;
		nxt_dv       = dv_ff;
		nxt_rxd      = rxd_ff;
		nxt_rstb     = 1'b0;
		nxt_link_cnt = link_hit ? 24'(LINK_CYC) : (link_cnt_ff == '0 ? '0 : link_cnt_ff - 24'h1);
		nxt_link     = link_cnt_ff != '0; // see RULE_08, RULE_12, RULE_14
		case (rx_st_ff)
			PFR_RX_HUNT: begin
				if (speed_100 ? ssd_hit : sh_in[9:2] == PRE_10_PAT) begin
					nxt_dv    = 1'b1;
					nxt_rxd   = PRE_NIB; // see RULE_05, RULE_11
					nxt_rstb  = 1'b1;
					nxt_rcnt  = 3'h0;
					nxt_rx_st = speed_100 ? PFR_RX_PRE : PFR_RX_DATA;
				end
			end
			PFR_RX_PRE: begin
				nxt_rxd   = PRE_NIB; // see RULE_05
				nxt_rstb  = 1'b1;
				nxt_rx_st = PFR_RX_DATA;
			end
			PFR_RX_DATA: begin
				if (speed_100 && rsym_done && sh_in[9:5] == pfr_rev5(SYM_T)) begin
					nxt_dv    = 1'b0; // see RULE_06
					nxt_rx_st = PFR_RX_HUNT;
				end else if (!speed_100 && ones_ff == IDL_ONES) begin
					nxt_dv    = 1'b0;
					nxt_rx_st = PFR_RX_HUNT;
				end else if (rsym_done) begin
					nxt_rstb = 1'b1; // see RULE_02
					nxt_rxd  = speed_100 ? pfr_decode(sh_in[9:5]) : sh_in[9:6]; // see RULE_09, RULE_16
				end
			end
			default: begin
				nxt_rx_st = PFR_RX_HUNT;
				nxt_dv    = 1'b0;
			end
		endcase
		// Duplex handling on the MII status lines
		nxt_crs = full_duplex ? nxt_dv : (nxt_dv || tx_st_ff != PFR_TX_IDLE); // see RULE_13
		nxt_col = !full_duplex && nxt_dv && tx_st_ff != PFR_TX_IDLE; // see RULE_13
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_meta_ff  <= 1'b0;
			rx_sync_ff  <= 1'b0;
			rx_st_ff    <= PFR_RX_HUNT;
			sh_ff       <= 10'h000;
			rcnt_ff     <= 3'h0;
			ones_ff     <= 8'h00;
			link_cnt_ff <= 24'h000000;
			dv_ff       <= 1'b0;
			rxd_ff      <= 4'h0;
			rstb_ff     <= 1'b0;
			link_ff     <= 1'b0;
			crs_ff      <= 1'b0;
			col_ff      <= 1'b0;
		end else begin
			rx_meta_ff  <= tp_rx;
			rx_sync_ff  <= rx_meta_ff;
			rx_st_ff    <= nxt_rx_st;
			sh_ff       <= nxt_sh;
			rcnt_ff     <= nxt_rcnt;
			ones_ff     <= nxt_ones;
			link_cnt_ff <= nxt_link_cnt;
			dv_ff       <= nxt_dv;
			rxd_ff      <= nxt_rxd;
			rstb_ff     <= nxt_rstb;
			link_ff     <= nxt_link;
			crs_ff      <= nxt_crs;
			col_ff      <= nxt_col;
		end
	end

	assign mii_tx_take   = take_ff;
	assign mii_rx_dv     = dv_ff;
	assign mii_rxd       = rxd_ff;
	assign mii_rx_strobe = rstb_ff;
	assign mii_crs       = crs_ff;
	assign mii_col       = col_ff;
	assign link_ok       = link_ff;
	assign tp_tx         = tp_tx_ff;

	chk_ssd_start: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE_03
		tx_st_ff == PFR_TX_IDLE && tx_last && mii_tx_en && speed_100
		|=> tx_st_ff == PFR_TX_SSD && sym_ff == pfr_rev5(SYM_J) ##5 sym_ff == pfr_rev5(SYM_K))
		else $error("start delimiter not sent");
	chk_esd_follow: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE_04
		tx_st_ff == PFR_TX_DATA && tx_last && !mii_tx_en && speed_100
		|=> sym_ff == pfr_rev5(SYM_T) ##5 sym_ff == pfr_rev5(SYM_R))
		else $error("end delimiter not sent");
	chk_idle_ones: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE_07
		tx_st_ff == PFR_TX_IDLE && tx_last && !mii_tx_en && speed_100
		|=> sym_ff == pfr_rev5(SYM_I))
		else $error("idle symbol missing");
	chk_take_nibble: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE_01
		tx_st_ff == PFR_TX_DATA && tx_last && mii_tx_en |=> take_ff ##1 !take_ff)
		else $error("nibble not taken");
	chk_ten_no_ssd: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE_10
		tx_st_ff == PFR_TX_IDLE && tx_last && mii_tx_en && !speed_100
		|=> tx_st_ff == PFR_TX_DATA && sym_ff[3:0] == $past(mii_txd))
		else $error("10M frame start wrong");
	chk_nlp_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE_12
		!sys_rst && nlp_fire |=> tp_tx_ff)
		else $error("link pulse missing");
	chk_rx_preamble: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE_05
		$rose(dv_ff) |-> rxd_ff == PRE_NIB && rstb_ff)
		else $error("preamble nibble not first");
	chk_rx_end: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE_06
		rx_st_ff == PFR_RX_DATA && speed_100 && rsym_done && sh_in[9:5] == pfr_rev5(SYM_T)
		|=> !dv_ff && !rstb_ff)
		else $error("delivery went on past end delimiter");
	chk_link_up: assert property (@(posedge ref_clk) disable iff (sys_rst) // see RULE_08
		link_hit |=> ##1 link_ff)
		else $error("link not reported");
endmodule
`default_nettype wire

/* File: pfr_far_end.sv */
// Remote line partner: loops the line back, optionally late, or goes silent
`timescale 1ns/1ps
`default_nettype none
module pfr_far_end (
	input  wire logic ref_clk,
	input  wire logic cut,
	input  wire logic slow,
	input  wire logic tp_tx,
	output logic      tp_rx
);
	logic echo_ff;
	logic late_ff;
	logic nxt_echo;
	logic nxt_late;
	// A cut cable rests low
	always_comb begin
		nxt_echo = cut ? 1'b0 : tp_tx;
		nxt_late = echo_ff;
	end
	always_ff @(posedge ref_clk) begin
		echo_ff <= nxt_echo;
		late_ff <= nxt_late;
	end
	assign tp_rx = slow ? late_ff : echo_ff;
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the stream framing block over a looped line
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pfr_pkg::*;
	localparam int unsigned NLP_T  = 64;
	localparam int unsigned LINK_T = 200;
	typedef struct {
		logic       spd;
		logic       fdx;
		logic       slow;
		int         len;
		logic [3:0] base;
		int         pre;
	} pfr_row_s;
	logic       ref_clk;
	logic       sys_rst     = 1'b1;
	logic       speed_100   = 1'b1;
	logic       full_duplex = 1'b1;
	logic       mii_tx_en   = 1'b0;
	logic [3:0] mii_txd     = 4'h0;
	logic       cut         = 1'b0;
	logic       slow        = 1'b0;
	logic       mii_tx_take, mii_rx_dv, mii_rx_strobe, mii_crs, mii_col;
	logic       link_ok, tp_tx, tp_rx;
	logic [3:0] mii_rxd;
	logic [3:0] rx_q[$];
	logic       col_seen, crs_seen;
	int         num_checks = 0;
	int         fail_count = 0;
	pfr_row_s   rows[5] = '{
		'{1'b1, 1'b1, 1'b0, 8, 4'h0, 6},
		'{1'b1, 1'b0, 1'b1, 1, 4'hf, 6},
		'{1'b0, 1'b1, 1'b0, 8, 4'h1, 0},
		'{1'b0, 1'b0, 1'b1, 1, 4'he, 0},
		'{1'b1, 1'b1, 1'b1, 16, 4'h7, 6}
	};

	pfr_stream #(.NLP_CYC(NLP_T), .LINK_CYC(LINK_T)) u_pfr_stream (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .speed_100(speed_100),
		.full_duplex(full_duplex), .mii_tx_en(mii_tx_en), .mii_txd(mii_txd),
		.mii_tx_take(mii_tx_take), .mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd),
		.mii_rx_strobe(mii_rx_strobe), .mii_crs(mii_crs), .mii_col(mii_col),
		.link_ok(link_ok), .tp_tx(tp_tx), .tp_rx(tp_rx));
	pfr_far_end u_pfr_far_end (
		.ref_clk(ref_clk), .cut(cut), .slow(slow), .tp_tx(tp_tx), .tp_rx(tp_rx));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (mii_rx_strobe === 1'b1 && mii_rx_dv === 1'b1) begin
			rx_q.push_back(mii_rxd);
		end
		if (mii_col === 1'b1) begin
			col_seen = 1'b1;
		end
		if (mii_crs === 1'b1) begin
			crs_seen = 1'b1;
		end
	end

	task automatic chk_bit(input string n, input logic e, input logic s);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %b seen %b", n, e, s);
		end
	endtask

	task automatic chk_vec(input string n, input logic [11:0] e, input logic [11:0] s);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic chk_cnt(input string n, input int e, input int s);
		num_checks++;
		if (s != e) begin
			fail_count++;
			$display("Error %s expected %0d seen %0d", n, e, s);
		end
	endtask

	// Select 1 waits on link_ok, 0 on mii_rx_dv
	task automatic wait_sig(input int sel, input logic v, input int lim);
		int k;
		k = 0;
		while (((sel != 0) ? link_ok : mii_rx_dv) !== v && k < lim) begin
			@(posedge ref_clk);
			k++;
		end
	endtask

	task automatic do_reset();
		sys_rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk_vec("reset_outs", 12'h000, {1'b0, mii_tx_take, mii_rx_dv, mii_rxd, mii_rx_strobe,
			mii_crs, mii_col, link_ok, tp_tx});
		sys_rst <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Nibble held until the take pulse shows it was sampled
	task automatic send_nib(input logic [3:0] n);
		int k;
		k = 0;
		mii_tx_en <= 1'b1;
		mii_txd   <= n;
		@(posedge ref_clk);
		while (mii_tx_take !== 1'b1 && k < 12) begin
			@(posedge ref_clk);
			k++;
		end
		chk_bit("tx_take", 1'b1, mii_tx_take);
	endtask

	task automatic run_row(input pfr_row_s r);
		logic [3:0] d[$];
		int         npre;
		speed_100   <= r.spd;
		full_duplex <= r.fdx;
		slow        <= r.slow;
		do_reset();
		wait_sig(1, 1'b1, 300);
		chk_bit("link_ok", 1'b1, link_ok);
		rx_q.delete();
		col_seen = 1'b0;
		crs_seen = 1'b0;
		d = {4'hd};
		for (int k = 0; k < r.len; k++) begin
			d.push_back(r.base + 4'(3 * k));
		end
		repeat (6) send_nib(PRE_NIB);
		foreach (d[i]) send_nib(d[i]);
		mii_tx_en <= 1'b0;
		wait_sig(0, 1'b0, 300);
		chk_bit("rx_dv_end", 1'b0, mii_rx_dv);
		npre = 0;
		while (rx_q.size() > 0 && rx_q[0] === PRE_NIB) begin
			void'(rx_q.pop_front());
			npre++;
		end
		if (r.pre > 0) begin
			chk_cnt("preamble", r.pre, npre);
			chk_cnt("nibbles", d.size(), rx_q.size());
		end else begin
			chk_cnt("preamble_seen", 1, int'(npre > 0));
		end
		foreach (d[i]) chk_vec("rxd", {8'h00, d[i]},
			{8'h00, (i < rx_q.size()) ? rx_q[i] : 4'hx});
		chk_bit("col", ~r.fdx, col_seen);
		chk_bit("crs", 1'b1, crs_seen);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge ref_clk);
		fail_count++;
		$display("Error watchdog expected finish seen timeout");
		wrap_up();
	end

	initial begin
		for (int i = 0; i < 5; i++) begin
			run_row(rows[i]);
			$display("test row %0d done", i);
		end
		// Cable cut and restored at each speed
		for (int s = 0; s < 2; s++) begin
			speed_100 <= s[0];
			slow      <= 1'b0;
			do_reset();
			wait_sig(1, 1'b1, 300);
			repeat (LINK_T + 20) @(posedge ref_clk);
			chk_bit("link_steady", 1'b1, link_ok);
			cut <= 1'b1;
			repeat (LINK_T / 2) @(posedge ref_clk);
			chk_bit("link_hold", 1'b1, link_ok);
			wait_sig(1, 1'b0, LINK_T);
			chk_bit("link_lost", 1'b0, link_ok);
			cut <= 1'b0;
			wait_sig(1, 1'b1, 300);
			chk_bit("link_back", 1'b1, link_ok);
			$display("test link %0d done", s);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
